// file: logic/sss_map.vh
// Purpose: constants for the sample series status logic
// Assumes: 200 MHz clock, sample ticks derived from it
// Notes: status codes are 8-bit values
`ifndef SSS_MAP_VH
`define SSS_MAP_VH
// ----------------------------------------
// common status codes
// ----------------------------------------
`define SSS_ST_OK 8'h00
`define SSS_ST_CORRUPT 8'h03
`define SSS_ST_WDOG 8'h10
`define SSS_ST_RESET 8'h11
`define SSS_ST_PARAM 8'h12
// ----------------------------------------
// parameter warning codes
// ----------------------------------------
`define SSS_PW_NONE 8'h00
`define SSS_PW_REDUCED 8'h53
`define SSS_PW_NOT_READY 8'h54
// ----------------------------------------
// sample rates and block lengths
// ----------------------------------------
`define SSS_RATE_LO 4'h2
`define SSS_RATE_HI 4'h4
`define SSS_BLK_256 12'h100
`define SSS_BLK_512 12'h200
`define SSS_BLK_1024 12'h400
`define SSS_BLK_2048 12'h800
// averaging period selector: 0..4 -> 10..50 s, 5..12 -> 1..8 min
`define SSS_AVG_STEP_S 9'h00a
`define SSS_AVG_MIN_S 9'h03c
`define SSS_AVG_SEL_MIN 4'h5
`define SSS_AVG_SEL_MAX 4'hc
// clock rate in Hz
`define SSS_CLK_HZ 200000000
`endif

// file: logic/sss_series_status.v
// Purpose: sample series tracking and status code tagging
// Assumes: settings and commands are synchronous single-clock inputs
// Notes: data values pass through; not-ready results are forced to zero
//
// Notes on behaviour
// - common status 0 when all valid, 3 when stored settings corrupt.
// - common status 16 after a software watchdog restart.
// - common status 17 after restart command or supply loss.
// - common status 18 when any output parameter is unreliable.
// - parameter warnings are 83 reduced quality and 84 not ready.
// - one common code per set; code 18 implies some parameter warning.
// - in text modes with tagging, flagged parameters get an asterisk mark.
// - wave and tide results output zero with not-ready until enough samples.
// - once ready, results recompute at each output interval from newest samples.
// - samples are appended at the selected sampling rate.
// - tide valid after averaging period times rate samples collected.
// - wave valid after block length divided by rate seconds.
// - rate is 2 Hz by default, 4 Hz with high rate enabled.
// - series cleared on power-up, restart command and relevant setting change.
// - sleep after needed points when interval exceeds acquisition time.
// - block length selects 256, 512, 1024 or 2048 samples.
// - averaging period 10 s to 50 s by 10, 1 to 8 min by 1.
`timescale 1ns/1ps
`include "sss_map.vh"
module sss_series_status #(
  parameter CLK_HZ = `SSS_CLK_HZ,
  parameter IVL_W = 16
) (
  // clock and reset
  input wire clk_i,
  input wire rst_i,
  // settings
  input wire [IVL_W-1:0] interval_s_i,
  input wire hi_rate_i,
  input wire [3:0] avg_sel_i,
  input wire tide_en_i,
  input wire wave_en_i,
  input wire spectrum_en_i,
  input wire [1:0] wave_block_length_i,
  input wire text_en_i,
  input wire text_mode_i,
  // events
  input wire restart_cmd_i,
  input wire wdog_restart_i,
  input wire supply_restart_i,
  input wire cfg_corrupt_i,
  input wire reduced_tide_i,
  input wire reduced_wave_i,
  // computed results
  input wire [31:0] tide_val_i,
  input wire [31:0] wave_val_i,
  // sampling
  output reg sample_o,
  output reg sleep_o,
  output reg [15:0] series_len_o,
  // output set
  output reg set_valid_o,
  output reg [7:0] common_st_o,
  output reg [7:0] tide_st_o,
  output reg [7:0] wave_st_o,
  output reg [31:0] tide_val_o,
  output reg [31:0] wave_val_o,
  output reg tide_mark_o,
  output reg wave_mark_o
);
  // ----------------------------------------
  // decode helpers
  // ----------------------------------------
  function [11:0] blk_len;
    input [1:0] sel;
    begin
      case (sel)
        2'd0: blk_len = `SSS_BLK_256;
        2'd1: blk_len = `SSS_BLK_512;
        2'd2: blk_len = `SSS_BLK_1024;
        default: blk_len = `SSS_BLK_2048;
      endcase
    end
  endfunction

  // averaging seconds; out of range selectors clamp to 8 min
  function [8:0] avg_secs;
    input [3:0] sel;
    reg [3:0] s;
    reg [8:0] p;
    begin
      s = (sel > `SSS_AVG_SEL_MAX) ? `SSS_AVG_SEL_MAX : sel;
      if (s < `SSS_AVG_SEL_MIN) begin
        p = {5'h0, s} + 9'h1;
        avg_secs = p * `SSS_AVG_STEP_S;
      end else begin
        p = {5'h0, s - `SSS_AVG_SEL_MIN} + 9'h1;
        avg_secs = p * `SSS_AVG_MIN_S;
      end
    end
  endfunction

  // ----------------------------------------
  // settings change and clear detect
  // ----------------------------------------
  wire [3:0] rate = hi_rate_i ? `SSS_RATE_HI : `SSS_RATE_LO;
  wire [IVL_W+9:0] cfg_now = {interval_s_i, hi_rate_i, avg_sel_i, tide_en_i,
                              spectrum_en_i, wave_en_i, wave_block_length_i};
  reg [IVL_W+9:0] cfg_q;
  reg boot_q;
  wire clear = boot_q || restart_cmd_i || (cfg_now != cfg_q);
  // required sample counts
  wire [15:0] tide_need = {7'h0, avg_secs(avg_sel_i)} * {12'h0, rate};
  wire [15:0] wave_need = {4'h0, blk_len(wave_block_length_i)};
  wire [15:0] need_t = tide_en_i ? tide_need : 16'h0;
  wire [15:0] need_w = wave_en_i ? wave_need : 16'h0;
  wire [15:0] need = (need_t > need_w) ? need_t : need_w;
  wire [IVL_W+3:0] ivl_pts = {4'h0, interval_s_i} * {{IVL_W{1'b0}}, rate};

  wire tick;
  sss_tick_gen #(.CLK_HZ(CLK_HZ)) u_tick (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .hi_rate_i(hi_rate_i),
    .restart_i(clear),
    .run_i(!sleep_o),
    .tick_o(tick)
  );

  // ----------------------------------------
  // series bookkeeping
  // ----------------------------------------
  reg [IVL_W+3:0] ivl_cnt_q; // samples since last output set, plus clock cycles spent asleep
  reg ready_q; // needed points once collected
  wire full = series_len_o >= need;
  wire ivl_end = tick && (ivl_cnt_q + 1'b1 >= ivl_pts) && (ivl_pts != 0);
  // sleep only when interval is longer than the acquisition window
  // compared at one common width; the bound on the count keeps the
  // remaining-slot difference from wrapping once the count passes the end
  wire [IVL_W+19:0] ivl_x = {16'h0, ivl_pts};
  wire [IVL_W+19:0] left_x = {16'h0, ivl_pts - ivl_cnt_q};
  wire [IVL_W+19:0] need_x = {{(IVL_W+4){1'b0}}, need};
  wire long_ivl = (ivl_x > need_x) && (ivl_cnt_q < ivl_pts) && (left_x > need_x);

  always @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      cfg_q <= {(IVL_W+10){1'b0}};
      boot_q <= 1'b1;
      series_len_o <= 16'h0;
      ivl_cnt_q <= {(IVL_W+4){1'b0}};
      sample_o <= 1'b0;
      sleep_o <= 1'b0;
      ready_q <= 1'b0;
    end else begin
      cfg_q <= cfg_now;
      boot_q <= 1'b0;
      sample_o <= tick && !clear;
      if (clear) begin
        series_len_o <= 16'h0;
        ivl_cnt_q <= {(IVL_W+4){1'b0}};
        sleep_o <= 1'b0;
        ready_q <= 1'b0;
      end else begin
        if (tick && series_len_o != 16'hffff)
          series_len_o <= series_len_o + 16'h1;
        if (tick)
          ivl_cnt_q <= ivl_end ? {(IVL_W+4){1'b0}} : ivl_cnt_q + 1'b1;
        else if (sleep_o)
          ivl_cnt_q <= ivl_cnt_q + 1'b1; // while asleep, counts one per clock cycle, not per sample slot
        if (full)
          ready_q <= 1'b1;
        // wake only in time to gather the points for the next computation
        sleep_o <= ready_q && full && long_ivl && !ivl_end;
      end
    end
  end

  // ----------------------------------------
  // output set and status tagging
  // ----------------------------------------
  wire tide_ok = series_len_o >= tide_need;
  wire wave_ok = series_len_o >= wave_need;
  reg [7:0] t_st, w_st, c_st;
  reg cmd_rst_q; // restart command seen, held until reported
  // per parameter codes, then common with fixed priority
  always @* begin
    t_st = `SSS_PW_NONE;
    w_st = `SSS_PW_NONE;
    if (tide_en_i)
      t_st = !tide_ok ? `SSS_PW_NOT_READY :
             (reduced_tide_i ? `SSS_PW_REDUCED : `SSS_PW_NONE);
    if (wave_en_i)
      w_st = !wave_ok ? `SSS_PW_NOT_READY :
             (reduced_wave_i ? `SSS_PW_REDUCED : `SSS_PW_NONE);
    if (cfg_corrupt_i)
      c_st = `SSS_ST_CORRUPT;
    else if (wdog_restart_i)
      c_st = `SSS_ST_WDOG;
    else if (supply_restart_i || cmd_rst_q)
      c_st = `SSS_ST_RESET;
    else if (t_st != `SSS_PW_NONE || w_st != `SSS_PW_NONE)
      c_st = `SSS_ST_PARAM;
    else
      c_st = `SSS_ST_OK;
  end

  // all codes latch together at each output interval
  always @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      set_valid_o <= 1'b0;
      common_st_o <= `SSS_ST_OK;
      tide_st_o <= `SSS_PW_NONE;
      wave_st_o <= `SSS_PW_NONE;
      tide_val_o <= 32'h0;
      wave_val_o <= 32'h0;
      tide_mark_o <= 1'b0;
      wave_mark_o <= 1'b0;
      cmd_rst_q <= 1'b0;
    end else begin
      set_valid_o <= ivl_end && !clear;
      // the command pulse lands in a suppressed set, so hold it for the next one
      if (restart_cmd_i)
        cmd_rst_q <= 1'b1;
      else if (ivl_end && !clear)
        cmd_rst_q <= 1'b0;
      if (ivl_end && !clear) begin
        common_st_o <= c_st;
        tide_st_o <= t_st;
        wave_st_o <= w_st;
        tide_val_o <= (t_st == `SSS_PW_NOT_READY) ? 32'h0 : tide_val_i;
        wave_val_o <= (w_st == `SSS_PW_NOT_READY) ? 32'h0 : wave_val_i;
        tide_mark_o <= text_mode_i && text_en_i && (t_st != `SSS_PW_NONE);
        wave_mark_o <= text_mode_i && text_en_i && (w_st != `SSS_PW_NONE);
      end
    end
  end
endmodule

// file: logic/sss_tick_gen.v
// Purpose: sample tick generator at 2 Hz or 4 Hz
// Assumes: clock at the rate given by the map header
// Notes: restarts its count whenever the series is cleared
`timescale 1ns/1ps
`include "sss_map.vh"
module sss_tick_gen #(
  parameter CLK_HZ = `SSS_CLK_HZ
) (
  // clock and reset
  input wire clk_i,
  input wire rst_i,
  // control
  input wire hi_rate_i,
  input wire restart_i,
  input wire run_i,
  // tick
  output reg tick_o
);
  localparam [31:0] DIV_LO = CLK_HZ / `SSS_RATE_LO;
  localparam [31:0] DIV_HI = CLK_HZ / `SSS_RATE_HI;
  reg [31:0] cnt_q;
  wire [31:0] lim = hi_rate_i ? DIV_HI : DIV_LO;
  // divider; reset to zero while asleep so no tick is made
  always @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      cnt_q <= 32'h0;
      tick_o <= 1'b0;
    end else if (restart_i || !run_i) begin
      cnt_q <= 32'h0;
      tick_o <= 1'b0;
    end else if (cnt_q >= lim - 32'h1) begin
      cnt_q <= 32'h0;
      tick_o <= 1'b1;
    end else begin
      cnt_q <= cnt_q + 32'h1;
      tick_o <= 1'b0;
    end
  end
endmodule

// file: tb/sss_host_model.sv
// Purpose: host side model handing results and logging sets
// Assumes: results held steady so pass-through is checkable
// Notes: values are arbitrary
`timescale 1ns/1ps
module sss_host_model #(
  parameter [31:0] TIDE_V = 32'h0000_1234,
  parameter [31:0] WAVE_V = 32'h0000_0abc
) (
  // clock and reset
  input wire clk_i,
  input wire rst_i,
  // link
  input wire set_valid_i,
  output wire [31:0] tide_val_o,
  output wire [31:0] wave_val_o,
  output reg [15:0] n_sets_o
);
  assign tide_val_o = TIDE_V;
  assign wave_val_o = WAVE_V;
  // logger counts sets it has taken
  always @(posedge clk_i or posedge rst_i) begin
    if (rst_i) n_sets_o <= 16'h0;
    else if (set_valid_i) n_sets_o <= n_sets_o + 16'h1;
  end
endmodule

// file: tb/sss_props.sv
// Purpose: checker for the sample series status block
// Assumes: CLK_HZ of 8, so 4 cycles a sample at 2 Hz, 2 at 4 Hz
// Notes: bound to the design from the test top
`timescale 1ns/1ps
module sss_props #(
  parameter CLK_HZ = 8
) (
  // clock and reset
  input wire clk_i,
  input wire rst_i,
  // watched settings and outputs
  input wire hi_rate_i,
  input wire [3:0] avg_sel_i,
  input wire tide_en_i,
  input wire sample_o,
  input wire [15:0] series_len_o,
  input wire set_valid_o,
  input wire [7:0] common_st_o,
  input wire [7:0] tide_st_o,
  input wire [7:0] wave_st_o,
  input wire [31:0] tide_val_o,
  input wire [31:0] wave_val_o,
  input wire tide_mark_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // tide need in samples; a margin of one covers the set edge
  wire [3:0] sel_w = (avg_sel_i > 4'hc) ? 4'hc : avg_sel_i;
  wire [15:0] per_w = (sel_w < 4'h5) ? (sel_w + 16'h1) * 16'h000a : (sel_w - 16'h4) * 16'h003c;
  wire [15:0] need_w = hi_rate_i ? per_w * 16'h0004 : per_w * 16'h0002;
  sequence s_gap;
    !sample_o [*3];
  endsequence
  chk_lo_rate: assert property (sample_o && !hi_rate_i |=> s_gap)
    else $error("sample spacing short at 2 Hz");
  chk_hi_rate: assert property (sample_o && hi_rate_i |=> !sample_o)
    else $error("sample spacing short at 4 Hz");
  chk_tide_wait: assert property
    (set_valid_o && tide_en_i && series_len_o + 16'h1 < need_w |-> tide_st_o == 8'h54)
    else $error("tide ready too early");
  chk_tide_zero: assert property (set_valid_o && tide_st_o == 8'h54 |-> tide_val_o == 32'h0)
    else $error("tide value not zero");
  chk_wave_zero: assert property (set_valid_o && wave_st_o == 8'h54 |-> wave_val_o == 32'h0)
    else $error("wave value not zero");
  chk_warn_pair: assert property
    (set_valid_o && common_st_o == 8'h12 |-> tide_st_o != 8'h00 || wave_st_o != 8'h00)
    else $error("common warning without parameter code");
  chk_code_set: assert property
    (set_valid_o |-> common_st_o inside {8'h00, 8'h03, 8'h10, 8'h11, 8'h12}
      && tide_st_o inside {8'h00, 8'h53, 8'h54} && wave_st_o inside {8'h00, 8'h53, 8'h54})
    else $error("illegal status code");
  chk_hold_codes: assert property (!set_valid_o |-> $stable(common_st_o))
    else $error("common code moved outside a set");
  chk_mark_flag: assert property (tide_mark_o |-> tide_st_o != 8'h00)
    else $error("mark without code");
  chk_clear_len: assert property ($changed(avg_sel_i) |-> ##[1:2] series_len_o == 16'h0)
    else $error("series not cleared");
endmodule

// file: tb/sss_series_status_test.sv
// Purpose: directed test of the sample series status block
// Assumes: CLK_HZ of 8 keeps sample periods a few cycles
// Notes: inputs move at the falling edge
`timescale 1ns/1ps
module sss_series_status_test;
  reg clk_i, rst_i, hi_rate_i, tide_en_i, wave_en_i, spectrum_en_i, text_en_i, text_mode_i;
  reg restart_cmd_i, wdog_restart_i, supply_restart_i, cfg_corrupt_i, reduced_tide_i;
  reg reduced_wave_i;
  reg [15:0] interval_s_i;
  reg [3:0] avg_sel_i;
  reg [1:0] wave_block_length_i;
  wire [31:0] tide_val_i, wave_val_i, tide_val_o, wave_val_o;
  wire [15:0] series_len_o, n_sets;
  wire [7:0] common_st_o, tide_st_o, wave_st_o;
  wire sample_o, sleep_o, set_valid_o, tide_mark_o, wave_mark_o;
  integer fail_count, n_checks, i;
  always #2.5 clk_i = ~clk_i;
  sss_series_status #(.CLK_HZ(8)) uut (.clk_i(clk_i), .rst_i(rst_i),
    .interval_s_i(interval_s_i), .hi_rate_i(hi_rate_i), .avg_sel_i(avg_sel_i),
    .tide_en_i(tide_en_i), .wave_en_i(wave_en_i), .spectrum_en_i(spectrum_en_i),
    .wave_block_length_i(wave_block_length_i), .text_en_i(text_en_i),
    .text_mode_i(text_mode_i), .restart_cmd_i(restart_cmd_i),
    .wdog_restart_i(wdog_restart_i), .supply_restart_i(supply_restart_i),
    .cfg_corrupt_i(cfg_corrupt_i), .reduced_tide_i(reduced_tide_i),
    .reduced_wave_i(reduced_wave_i), .tide_val_i(tide_val_i), .wave_val_i(wave_val_i),
    .sample_o(sample_o), .sleep_o(sleep_o), .series_len_o(series_len_o),
    .set_valid_o(set_valid_o), .common_st_o(common_st_o), .tide_st_o(tide_st_o),
    .wave_st_o(wave_st_o), .tide_val_o(tide_val_o), .wave_val_o(wave_val_o),
    .tide_mark_o(tide_mark_o), .wave_mark_o(wave_mark_o));
  sss_host_model hm (.clk_i(clk_i), .rst_i(rst_i), .set_valid_i(set_valid_o),
    .tide_val_o(tide_val_i), .wave_val_o(wave_val_i), .n_sets_o(n_sets));
  task cmp(input [31:0] e, input [31:0] g);
    begin
      n_checks = n_checks + 1;
      if (g !== e) begin
        fail_count = fail_count + 1;
        $display("[FAIL] t=%0t exp=%h got=%h", $time, e, g);
      end
    end
  endtask
  // bounded wait: w=0 for a set, else for series length n
  task wait_on(input w, input [15:0] n);
    integer k;
    begin
      k = 0;
      @(negedge clk_i);
      while (k < 4000 && (w ? series_len_o < n : set_valid_o !== 1'b1)) begin
        @(negedge clk_i);
        k = k + 1;
      end
      if (k >= 4000) fail_count = fail_count + 1;
    end
  endtask
  // two sets, so the first one may predate the input change
  task sets2;
    begin
      wait_on(1'b0, 16'h0);
      wait_on(1'b0, 16'h0);
    end
  endtask
  task finish_test;
    begin
      $display("counts: checks=%0d fails=%0d sets=%0d", n_checks, fail_count, n_sets);
      if (fail_count == 0 && n_checks > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
    end
  endtask
  initial begin
    #50000;
    fail_count = fail_count + 1;
    finish_test;
  end
  initial begin
    {clk_i, hi_rate_i, wave_en_i, spectrum_en_i, text_en_i, text_mode_i, restart_cmd_i} = 7'h0;
    {wdog_restart_i, supply_restart_i, cfg_corrupt_i, reduced_tide_i, reduced_wave_i} = 5'h0;
    {rst_i, tide_en_i, interval_s_i, avg_sel_i, wave_block_length_i} = {2'h3, 16'h1, 4'h1, 2'h0};
    fail_count = 0;
    n_checks = 0;
    repeat (5) @(negedge clk_i);
    rst_i = 1'b0;
    // causes in priority order while tide (40 samples) fills
    for (i = 0; i < 4; i = i + 1) begin
      {cfg_corrupt_i, wdog_restart_i, supply_restart_i} = 3'h4 >> i;
      sets2;
      cmp(i == 0 ? 8'h03 : i == 1 ? 8'h10 : i == 2 ? 8'h11 : 8'h12, common_st_o);
    end
    cmp(8'h54, tide_st_o);
    cmp(32'h0, tide_val_o);
    $display("test causes done");
    wait_on(1'b1, 16'd42);
    sets2;
    cmp({8'h00, 8'h00}, {common_st_o, tide_st_o});
    cmp(32'h0000_1234, tide_val_o);
    {reduced_tide_i, text_en_i, text_mode_i} = 3'h7;
    sets2;
    cmp({8'h12, 8'h53}, {common_st_o, tide_st_o});
    cmp(32'h1, tide_mark_o);
    $display("test ready done");
    // each setting change empties the series
    for (i = 0; i < 4; i = i + 1) begin
      wait_on(1'b1, 16'd3);
      case (i)
        0: avg_sel_i = 4'h0;
        1: spectrum_en_i = 1'b1;
        2: wave_block_length_i = 2'h1;
        default: interval_s_i = 16'h2;
      endcase
      repeat (3) @(negedge clk_i);
      cmp(32'h0, series_len_o);
    end
    {reduced_tide_i, hi_rate_i, wave_en_i, wave_block_length_i, interval_s_i} = {5'h0c, 16'h1};
    wait_on(1'b1, 16'd200);
    wait_on(1'b0, 16'h0);
    cmp({8'h12, 8'h00, 8'h54}, {common_st_o, tide_st_o, wave_st_o});
    cmp(32'h0, wave_val_o);
    wait_on(1'b1, 16'd258);
    sets2;
    cmp({8'h00, 8'h00}, {common_st_o, wave_st_o});
    cmp(32'h0000_0abc, wave_val_o);
    reduced_wave_i = 1'b1;
    sets2;
    cmp({8'h12, 8'h53, 8'h01}, {common_st_o, wave_st_o, 7'h0, wave_mark_o});
    $display("test clear and wave done");
    // the first set after the command must carry the restart code
    {restart_cmd_i, text_mode_i} = 2'h2;
    @(negedge clk_i);
    restart_cmd_i = 1'b0;
    wait_on(1'b0, 16'h0);
    cmp({8'h11, 8'h54, 8'h00}, {common_st_o, wave_st_o, 7'h0, wave_mark_o});
    $display("test restart done");
    // 1 min at 4 Hz needs 240 points, interval of 256 points leaves a sleep
    {avg_sel_i, wave_en_i, reduced_wave_i, interval_s_i} = {4'h5, 2'h0, 16'h40};
    wait_on(1'b0, 16'h0);
    cmp({8'h00, 8'h00}, {common_st_o, tide_st_o});
    @(negedge clk_i);
    cmp(32'h1, sleep_o);
    repeat (2) @(negedge clk_i);
    i = 0;
    repeat (8) begin
      @(negedge clk_i);
      i = i + sample_o;
    end
    cmp(32'h0, i);
    wait_on(1'b0, 16'h0);
    cmp(32'h0, sleep_o);
    $display("test sleep done");
    finish_test;
  end
endmodule
bind sss_series_status sss_props #(.CLK_HZ(CLK_HZ)) u_props (.clk_i(clk_i), .rst_i(rst_i),
  .hi_rate_i(hi_rate_i), .avg_sel_i(avg_sel_i), .tide_en_i(tide_en_i), .sample_o(sample_o),
  .series_len_o(series_len_o), .set_valid_o(set_valid_o), .common_st_o(common_st_o),
  .tide_st_o(tide_st_o), .wave_st_o(wave_st_o), .tide_val_o(tide_val_o),
  .wave_val_o(wave_val_o), .tide_mark_o(tide_mark_o));
